// >>> core/fpbp_pkg.sv
package fpbp_pkg;

	// ----------------------------------------------------------------
	// widths and positions
	// ----------------------------------------------------------------
	localparam int FPBP_DATA_W = 16;
	localparam int FPBP_ADDR_W = 26;
	localparam int FPBP_UPPER_LSB = 16;
	localparam int FPBP_AAD_HI_W = 10;
	localparam int FPBP_CFG_AAD_BIT = 4;
	localparam int FPBP_CFG_W = 16;
	localparam logic [FPBP_CFG_W-1:0] FPBP_CFG_RST = 16'h0000;
	localparam logic [FPBP_ADDR_W-1:0] FPBP_ADDR_RST = 26'h0000000;
	localparam logic [FPBP_DATA_W-1:0] FPBP_DATA_RST = 16'h0000;
	localparam logic [1:0] FPBP_TOP_256 = 2'h0;
	localparam logic [1:0] FPBP_TOP_512 = 2'h1;
	localparam logic [1:0] FPBP_TOP_1G = 2'h2;

	// bus state seen by the pins
	typedef enum logic [2:0] {
		FPBP_ST_RESET = 3'h0,
		FPBP_ST_STANDBY = 3'h1,
		FPBP_ST_OUT_DIS = 3'h2,
		FPBP_ST_READ = 3'h3,
		FPBP_ST_WRITE = 3'h4
	} fpbp_state_t;

	// control pins after synchronisation
	typedef struct packed {
		logic chip_select_n;
		logic output_enable_n;
		logic write_enable_n;
		logic address_valid_n;
		logic burst_clk;
		logic write_protect_n;
		logic reset_n;
	} fpbp_ctrl_t;

	// write request toward the array core
	typedef struct packed {
		logic [FPBP_ADDR_W-1:0] addr;
		logic [FPBP_DATA_W-1:0] data;
	} fpbp_wreq_t;

endpackage

// >>> core/fpbp_sync.sv
`timescale 1ns/10ps
`default_nettype none
// two-stage synchroniser, one per bit
module fpbp_sync
#(
	parameter int WIDTH = 1
)
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] async_in,
	input wire logic [WIDTH-1:0] rst_val_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	// reset value is a tie-off constant at the instance
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			meta_r <= rst_val_in;
			sync_r <= rst_val_in;
		end
		else
		begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;
endmodule
`default_nettype wire

// >>> core/fpbp_pins.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// R1 - chip select low selects the die; high deselects into standby
// R2 - host holds output enable low for reads, high for writes
// R3 - host holds write enable low for writes, high for reads
// R4 - address accepted only while address valid is low; burst captures on clock rise
// R5 - burst reads are stepped by the host-supplied clock
// R6 - write protect low enables lock-down, high disables it
// R7 - reset low inhibits every operation
// R8 - not-ready output has selectable polarity; asserted means data invalid
// R9 - data bus takes writes and drives read data, status or info
// R10 - shared variant carries low address in address phase, then data
// R11 - host drives upper address bits on dedicated inputs each cycle
// R12 - host ties upper inputs low in address-address-data mode
// R13 - address bit zero is the least significant word bit
// R14 - top address bit in use depends on density
// R15 - config bit 4 selects address-address-data: low half then upper half
// R16 - reset aborts a program or erase in progress
// R17 - standby lets program or erase finish; outputs stay off
// R18 - output disable floats data; not-ready deasserted or floated by variant
// R19 - latched address held until next address valid pulse
// R20 - deselected or reset: no driver on the shared bus
module fpbp_pins
	import fpbp_pkg::*;
#(
	parameter bit SHARED_BUS_VARIANT = 1'b0,
	parameter logic [1:0] DENSITY = fpbp_pkg::FPBP_TOP_1G
)
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire fpbp_pkg::fpbp_ctrl_t ctrl_in,
	input wire logic [fpbp_pkg::FPBP_ADDR_W-1:0] addr_in,
	input wire logic [fpbp_pkg::FPBP_DATA_W-1:0] dq_in,
	output logic [fpbp_pkg::FPBP_DATA_W-1:0] dq_out,
	output logic dq_oe_out,
	output logic not_ready_out,
	output logic not_ready_oe_out,
	input wire logic [fpbp_pkg::FPBP_CFG_W-1:0] read_config_reg_in,
	input wire logic wait_active_high_in,
	input wire logic [fpbp_pkg::FPBP_DATA_W-1:0] rdata_in,
	input wire logic rdata_valid_in,
	input wire logic op_busy_in,
	output logic [fpbp_pkg::FPBP_ADDR_W-1:0] addr_out,
	output logic addr_strobe_out,
	output logic burst_step_out,
	output fpbp_pkg::fpbp_wreq_t wreq_out,
	output logic wreq_valid_out,
	output logic lockdown_en_out,
	output logic abort_out,
	output fpbp_pkg::fpbp_state_t state_out
);
	import fpbp_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisation
	// ----------------------------------------------------------------
	localparam int SYNC_W = $bits(fpbp_ctrl_t) + FPBP_ADDR_W + FPBP_DATA_W;
	localparam fpbp_ctrl_t CTRL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
	logic [SYNC_W-1:0] sync_w;
	fpbp_ctrl_t c_w;
	logic [FPBP_ADDR_W-1:0] a_w;
	logic [FPBP_DATA_W-1:0] d_w;

	fpbp_sync #(.WIDTH(SYNC_W)) u_sync (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.async_in({ctrl_in, addr_in, dq_in}),
		.rst_val_in({CTRL_IDLE, FPBP_ADDR_RST, FPBP_DATA_RST}),
		.sync_out(sync_w)
	);
	assign {c_w, a_w, d_w} = sync_w;

	// ----------------------------------------------------------------
	// bus state decode
	// ----------------------------------------------------------------
	logic in_reset_w;
	logic selected_w;
	logic aad_mode_w;
	logic reading_w;
	logic writing_w;
	fpbp_state_t state_w;
	assign in_reset_w = ~c_w.reset_n; // [R7]
	assign selected_w = ~in_reset_w & ~c_w.chip_select_n; // [R1]
	assign aad_mode_w = SHARED_BUS_VARIANT & read_config_reg_in[FPBP_CFG_AAD_BIT]; // [R15]
	assign reading_w = selected_w & ~c_w.output_enable_n & c_w.write_enable_n;
	assign writing_w = selected_w & c_w.output_enable_n & ~c_w.write_enable_n;
	assign state_w = in_reset_w ? FPBP_ST_RESET :
		~selected_w ? FPBP_ST_STANDBY :
		reading_w ? FPBP_ST_READ :
		writing_w ? FPBP_ST_WRITE : FPBP_ST_OUT_DIS;

	// ----------------------------------------------------------------
	// address path
	// ----------------------------------------------------------------
	// density mask keeps unused top bits at zero
	localparam logic [FPBP_ADDR_W-1:0] MASK_256 = 26'h0FFFFFF;
	localparam logic [FPBP_ADDR_W-1:0] MASK_512 = 26'h1FFFFFF;
	localparam logic [FPBP_ADDR_W-1:0] MASK_1G = 26'h3FFFFFF;
	logic [FPBP_ADDR_W-1:0] mask_w;
	logic [FPBP_ADDR_W-1:0] addr_src_w;
	logic [FPBP_ADDR_W-1:0] addr_r;
	logic adv_prev_r;
	logic clk_prev_r;
	logic adv_fall_w;
	logic clk_rise_w;
	logic capture_w;
	logic aad_lo_w;
	logic aad_hi_w;
	assign mask_w = (DENSITY == FPBP_TOP_256) ? MASK_256 :
		(DENSITY == FPBP_TOP_512) ? MASK_512 : MASK_1G; // [R14]
	// shared bus gives the low half on the data pins [R10]
	assign addr_src_w = SHARED_BUS_VARIANT ?
		{a_w[FPBP_ADDR_W-1:FPBP_UPPER_LSB], d_w} : a_w; // [R11] [R13]
	assign adv_fall_w = adv_prev_r & ~c_w.address_valid_n;
	assign clk_rise_w = ~clk_prev_r & c_w.burst_clk;
	// capture on clock rise while valid is low, or on the valid edge itself
	assign capture_w = selected_w & ~c_w.address_valid_n & ~aad_mode_w &
		(clk_rise_w | adv_fall_w); // [R4]
	// first address cycle in aad mode: output enable high carries the low half
	assign aad_lo_w = selected_w & aad_mode_w & ~c_w.address_valid_n &
		c_w.output_enable_n & clk_rise_w; // [R15]
	// second address cycle in aad mode: output enable low carries the upper half
	assign aad_hi_w = selected_w & aad_mode_w & ~c_w.address_valid_n &
		~c_w.output_enable_n & clk_rise_w; // [R15] [R12]

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in | in_reset_w)
		begin
			addr_r <= FPBP_ADDR_RST;
			adv_prev_r <= 1'b1;
			clk_prev_r <= 1'b0;
		end
		else
		begin
			adv_prev_r <= c_w.address_valid_n;
			clk_prev_r <= c_w.burst_clk;
			if (capture_w)
				addr_r <= addr_src_w & mask_w; // [R4]
			else if (aad_lo_w)
				addr_r <= {{(FPBP_ADDR_W-FPBP_DATA_W){1'b0}}, d_w}; // [R15]
			else if (aad_hi_w)
				addr_r <= {d_w[FPBP_AAD_HI_W-1:0], addr_r[FPBP_UPPER_LSB-1:0]} & mask_w;
			// otherwise the latched address stands [R19]
		end
	end

	// ----------------------------------------------------------------
	// array handshake and outputs
	// ----------------------------------------------------------------
	logic [FPBP_DATA_W-1:0] dq_r;
	logic dq_oe_r;
	logic strobe_r;
	logic step_r;
	logic we_prev_r;
	logic wvalid_r;
	fpbp_wreq_t wreq_r;
	logic lock_r;
	logic abort_r;
	logic nr_level_w;
	logic dq_drive_w;
	logic we_rise_w;
	assign we_rise_w = ~we_prev_r & c_w.write_enable_n;
	// drive only for a selected read cycle [R2] [R3] [R17] [R20]
	assign dq_drive_w = reading_w;
	// not-ready level before polarity [R8]
	assign nr_level_w = reading_w & ~rdata_valid_in;

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			dq_r <= FPBP_DATA_RST;
			dq_oe_r <= 1'b0;
			strobe_r <= 1'b0;
			step_r <= 1'b0;
			we_prev_r <= 1'b1;
			wvalid_r <= 1'b0;
			wreq_r <= '0;
			lock_r <= 1'b0;
			abort_r <= 1'b0;
		end
		else
		begin
			dq_r <= rdata_in; // [R9]
			dq_oe_r <= dq_drive_w; // [R18] [R20]
			strobe_r <= capture_w | aad_hi_w;
			step_r <= reading_w & c_w.address_valid_n & clk_rise_w; // [R5]
			we_prev_r <= c_w.write_enable_n;
			// write ends on write enable rise while still selected with output enable high
			wvalid_r <= selected_w & c_w.output_enable_n & ~we_prev_r &
				c_w.write_enable_n; // [R9]
			if (writing_w)
				wreq_r <= '{addr: addr_r, data: d_w};
			lock_r <= ~in_reset_w & ~c_w.write_protect_n; // [R6]
			abort_r <= in_reset_w & op_busy_in; // [R16]
		end
	end

	// edge term unused once the write window closes
	assign addr_out = addr_r;
	assign addr_strobe_out = strobe_r;
	assign burst_step_out = step_r;
	assign wreq_out = wreq_r;
	assign wreq_valid_out = wvalid_r & ~we_rise_w;
	assign lockdown_en_out = lock_r;
	assign abort_out = abort_r;
	assign state_out = state_w;
	assign dq_out = dq_r;
	assign dq_oe_out = dq_oe_r;
	// shared variant drives not-ready while selected, deasserted outside reads, else floats [R18] [R20]
	assign not_ready_oe_out = SHARED_BUS_VARIANT ? selected_w : dq_oe_r;
	// asserted level equals the polarity input, deasserted level its inverse
	assign not_ready_out = (nr_level_w & dq_oe_r) ^ ~wait_active_high_in; // [R8]

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	no_drive_reset_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R20]
		in_reset_w |=> !dq_oe_out) else $error("data driven in reset");
	no_drive_standby_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R17]
		!selected_w |=> !dq_oe_out) else $error("data driven in standby");
	out_disable_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R18]
		(selected_w && c_w.output_enable_n) |=> !dq_oe_out)
		else $error("data driven with output enable high");
	lockdown_lvl_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R6]
		(!in_reset_w && !c_w.write_protect_n) |=> lockdown_en_out)
		else $error("lock-down not enabled");
	addr_hold_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R19]
		(!capture_w && !aad_hi_w && !in_reset_w && !(aad_mode_w && clk_rise_w))
		|=> $stable(addr_r)) else $error("latched address moved");
	addr_take_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R4]
		capture_w |=> addr_r == ($past(addr_src_w) & mask_w))
		else $error("address not captured");
	aad_low_take_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R15]
		aad_lo_w |=> addr_r[FPBP_UPPER_LSB-1:0] == $past(d_w))
		else $error("low address half not captured");
	abort_on_reset_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R16]
		(in_reset_w && op_busy_in) |=> abort_out) else $error("operation not aborted");
	sequence rd_seq;
		reading_w ##1 dq_oe_out;
	endsequence
	read_drive_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R9]
		reading_w |-> rd_seq) else $error("read not driven");
	nr_idle_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [R8]
		!dq_oe_out |-> not_ready_out == !wait_active_high_in)
		else $error("not-ready asserted while idle");
endmodule
`default_nettype wire

// >>> verif/fpbp_host.sv
`timescale 1ns/10ps
`default_nettype none
// host controller model standing on the pin side of the flash bus
module fpbp_host
(
	input wire logic sys_clk_in,
	input wire logic [fpbp_pkg::FPBP_DATA_W-1:0] dev_dq_in,
	input wire logic dev_oe_in,
	output fpbp_pkg::fpbp_ctrl_t ctrl_out,
	output logic [fpbp_pkg::FPBP_ADDR_W-1:0] addr_out,
	output logic [fpbp_pkg::FPBP_DATA_W-1:0] bus_out
);
	import fpbp_pkg::*;
	logic [FPBP_DATA_W-1:0] drv_r = 16'h0000;
	logic [FPBP_DATA_W-1:0] last_r = 16'h0000;
	logic drv_oe_r = 1'b0;
	// released data line shows a pattern that flips every cycle
	assign bus_out = dev_oe_in ? dev_dq_in : (drv_oe_r ? drv_r : ~last_r);
	always_ff @(posedge sys_clk_in)
		last_r <= bus_out;
	// idle pins: deselected, out of reset
	initial
	begin
		ctrl_out = 7'h5B;
		addr_out = 26'h0000000;
	end
	// mode 0 idle, 1 read, 2 write; enables follow the mode alone
	task automatic drive(input logic cs_n, input logic [1:0] mode, input logic adv_n,
		input logic clk, input logic wp_n, input logic rst_n,
		input logic [FPBP_ADDR_W-1:0] a, input logic [FPBP_DATA_W-1:0] d);
		@(posedge sys_clk_in);
		ctrl_out <= {cs_n, mode != 2'h1, mode != 2'h2, adv_n, clk, wp_n, rst_n};
		addr_out <= a;
		drv_r <= d;
		// host drives the shared bus for writes and during every address phase
		drv_oe_r <= (mode == 2'h2) | ~adv_n;
	endtask
endmodule
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	import fpbp_pkg::*;
	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic pol = 1'b0, rvalid = 1'b0, busy = 1'b0;
	logic [FPBP_DATA_W-1:0] rdata = 16'h0000;
	fpbp_ctrl_t ctrl;
	logic [FPBP_ADDR_W-1:0] addr, addr_lat;
	logic [FPBP_DATA_W-1:0] bus, dq;
	logic dq_oe, nr, nr_oe, astb, bstep, wvalid, lock, abort;
	fpbp_wreq_t wreq;
	fpbp_state_t st;
	fpbp_ctrl_t ctrl2;
	logic [FPBP_ADDR_W-1:0] addr2, addr_lat2;
	logic [FPBP_DATA_W-1:0] bus2, dq2;
	logic dq_oe2, nr_oe2, astb2;
	int fail_count = 0;
	int n_checks = 0;
	always #5 sys_clk_in = ~sys_clk_in;
	fpbp_host host (.sys_clk_in(sys_clk_in), .dev_dq_in(dq), .dev_oe_in(dq_oe),
		.ctrl_out(ctrl), .addr_out(addr), .bus_out(bus));
	fpbp_pins #(.SHARED_BUS_VARIANT(1'b0), .DENSITY(FPBP_TOP_256)) DUT (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .ctrl_in(ctrl), .addr_in(addr),
		.dq_in(bus), .dq_out(dq), .dq_oe_out(dq_oe), .not_ready_out(nr),
		.not_ready_oe_out(nr_oe), .read_config_reg_in(16'h0000),
		.wait_active_high_in(pol), .rdata_in(rdata), .rdata_valid_in(rvalid),
		.op_busy_in(busy), .addr_out(addr_lat), .addr_strobe_out(astb),
		.burst_step_out(bstep), .wreq_out(wreq), .wreq_valid_out(wvalid),
		.lockdown_en_out(lock), .abort_out(abort), .state_out(st));
	// shared-bus variant with address-address-data mode switched on
	fpbp_host host2 (.sys_clk_in(sys_clk_in), .dev_dq_in(dq2), .dev_oe_in(dq_oe2),
		.ctrl_out(ctrl2), .addr_out(addr2), .bus_out(bus2));
	fpbp_pins #(.SHARED_BUS_VARIANT(1'b1), .DENSITY(FPBP_TOP_1G)) DUT_AAD (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .ctrl_in(ctrl2), .addr_in(addr2),
		.dq_in(bus2), .dq_out(dq2), .dq_oe_out(dq_oe2), .not_ready_out(),
		.not_ready_oe_out(nr_oe2), .read_config_reg_in(16'h0010),
		.wait_active_high_in(pol), .rdata_in(rdata), .rdata_valid_in(rvalid),
		.op_busy_in(busy), .addr_out(addr_lat2), .addr_strobe_out(astb2),
		.burst_step_out(), .wreq_out(), .wreq_valid_out(),
		.lockdown_en_out(), .abort_out(), .state_out());
	// ----------------------------------------------------------------
	// checking helpers
	// ----------------------------------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// bounded wait on a strobe: 0 address, 1 drive, 2 write, 3 abort, 4 shared address
	task automatic wait_hi(input int sel);
		for (int i = 0; i < 20; i++)
		begin
			@(negedge sys_clk_in);
			if ((sel == 0 && astb === 1'b1) || (sel == 1 && dq_oe === 1'b1) ||
				(sel == 2 && wvalid === 1'b1) || (sel == 3 && abort === 1'b1) ||
				(sel == 4 && astb2 === 1'b1))
				return;
		end
		fail_count++;
		$display("mismatch at %0t: got %h expected %h", $time, 1'b0, 1'b1);
		summarize();
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_read(input logic p);
		int cnt;
		cnt = 0;
		host.drive(0, 1, 0, 0, 1, 1, 26'h3ABCDEF, 16'h0000);
		pol <= p;
		wait_hi(0);
		chk(addr_lat, 26'h0ABCDEF);
		wait_hi(1);
		@(posedge sys_clk_in);
		rdata <= 16'h5A3C;
		rvalid <= 1'b1;
		repeat (3) @(negedge sys_clk_in);
		chk(dq, 16'h5A3C);
		chk(nr, !p);
		chk(nr_oe, 1'b1);
		// address pins move with valid high: latch must hold, clock steps burst
		for (int k = 0; k < 3; k++)
		begin
			host.drive(0, 1, 1, 1, 1, 1, 26'h1234567, 16'h0000);
			repeat (4) @(negedge sys_clk_in) if (bstep === 1'b1) cnt++;
			host.drive(0, 1, 1, 0, 1, 1, 26'h1234567, 16'h0000);
			repeat (4) @(negedge sys_clk_in) if (bstep === 1'b1) cnt++;
		end
		chk(cnt, 3);
		chk(addr_lat, 26'h0ABCDEF);
		host.drive(1, 0, 1, 0, 1, 1, 26'h0000000, 16'h0000);
		rvalid <= 1'b0;
		repeat (5) @(negedge sys_clk_in);
		$display("read test done, polarity %0d", p);
	endtask
	task automatic t_write();
		host.drive(0, 2, 0, 0, 1, 1, 26'h0F0F0F0, 16'hC33C);
		repeat (4) @(negedge sys_clk_in);
		chk(dq_oe, 1'b0);
		host.drive(0, 0, 1, 0, 1, 1, 26'h0F0F0F0, 16'hC33C);
		wait_hi(2);
		chk(wreq.addr, 26'h0F0F0F0);
		chk(wreq.data, 16'hC33C);
		$display("write test done");
	endtask
	task automatic t_idle();
		host.drive(1, 1, 0, 0, 1, 1, 26'h0000010, 16'h0000);
		busy <= 1'b1;
		repeat (6) @(negedge sys_clk_in);
		chk(st, FPBP_ST_STANDBY);
		chk(dq_oe, 1'b0);
		chk(nr_oe, 1'b0);
		chk(abort, 1'b0);
		host.drive(0, 0, 1, 0, 1, 1, 26'h0000010, 16'h0000);
		repeat (6) @(negedge sys_clk_in);
		chk(st, FPBP_ST_OUT_DIS);
		chk(dq_oe, 1'b0);
		$display("standby and output disable test done");
	endtask
	task automatic t_reset();
		host.drive(0, 1, 0, 0, 1, 0, 26'h0000020, 16'h0000);
		wait_hi(3);
		repeat (2) @(negedge sys_clk_in);
		chk(st, FPBP_ST_RESET);
		chk(dq_oe, 1'b0);
		chk(astb, 1'b0);
		host.drive(1, 0, 1, 0, 1, 1, 26'h0000000, 16'h0000);
		busy <= 1'b0;
		repeat (6) @(negedge sys_clk_in);
		$display("reset test done");
	endtask
	task automatic t_protect();
		for (int w = 0; w < 2; w++)
		begin
			host.drive(1, 0, 1, 0, w[0], 1, 26'h0000000, 16'h0000);
			repeat (5) @(negedge sys_clk_in);
			chk(lock, !w[0]);
		end
		$display("write protect test done");
	endtask
	// low half with output enable high, upper half on the low data bits with it low
	task automatic t_aad();
		host2.drive(0, 0, 0, 1, 1, 1, 26'h0000000, 16'hBEEF);
		repeat (4) @(negedge sys_clk_in);
		host2.drive(0, 0, 0, 0, 1, 1, 26'h0000000, 16'hBEEF);
		repeat (4) @(negedge sys_clk_in);
		host2.drive(0, 1, 0, 1, 1, 1, 26'h0000000, 16'h02A5);
		wait_hi(4);
		chk(addr_lat2, 26'h2A5BEEF);
		chk(nr_oe2, 1'b1);
		host2.drive(1, 0, 1, 0, 1, 1, 26'h0000000, 16'h0000);
		repeat (5) @(negedge sys_clk_in);
		$display("address-address-data test done");
	endtask
	// reset, then every scenario in turn
	initial
	begin
		repeat (5) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		repeat (3) @(posedge sys_clk_in);
		t_read(1'b0);
		t_read(1'b1);
		t_write();
		t_idle();
		t_reset();
		t_protect();
		t_aad();
		summarize();
	end
endmodule
`default_nettype wire
